// >>> rtl/lbf_core.sv
// Light barrier pulse scheduler, receive gating and dual pulse filter with APB registers
//
// What this block does
// - Standalone mode fires LED pulses repeatedly at the programmed scan period.
// - Controlled mode fires exactly one LED pulse per trigger rising edge.
// - Controlled mode enables the receiver only while the trigger is high.
// - Trigger edge is synchronised to the clock before it times anything.
// - Standalone pulse timing and filter evaluation are paced by the scan period.
// - Each LED pulse lasts the programmed pulse length.
// - Each slot classifies detect and reserve as valid or missing separately.
// - Valid pulse adds weight times 1024; weight zero adds 32 times 1024.
// - Counter saturates at 2 to the 15 after an increment.
// - Counter at its upper limit drives detect output low.
// - Missing pulse subtracts two to the power of the missing weight.
// - Counter clamps at zero after a decrement.
// - Counter at zero drives detect high; between limits output holds.
// - Reserve path has its own counter with identical rules.
// - Detect stays low across slots while valid pulses keep arriving.
// - Filters change only in a pulse slot and hold otherwise.
// - Mode field 101 is standalone, 011 is controlled.
// - Drive sense 0 gives active-high LED, 1 gives active-low LED.
// - Pulse length code 000 to 101 gives 1 to 6 microseconds.
// - Reserve output set by its filter only while detect is active, released together with detect.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
module lbf_core (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output      logic [31:0]  prdata,
  output      logic         pready,
  output      logic         pslverr,
  input  wire logic         trigger_in,
  input  wire logic         detect_hit,
  input  wire logic         reserve_hit,
  output      logic         led_out,
  output      logic         rx_enable,
  output      logic [3:0]   detect_threshold,
  output      logic [3:0]   reserve_threshold,
  output      logic         detect_out_n,
  output      logic         detect_out_alt,
  output      logic         reserve_out_n,
  output      logic         detect_pulse_flag,
  output      logic         reserve_pulse_flag
);
  import lbf_pkg::*;

  lbf_cfg_t         cfg_r;
  lbf_pins_t        pins_async;
  lbf_pins_t        pins_sync;
  lbf_state_t       state_r;
  lbf_state_t       state_nxt;
  logic [PRE_W-1:0] pre_r;
  logic [16:0]      us_r;
  logic [PLEN_W-1:0] plen_r;
  logic             trig_prev_r;
  logic             led_out_r;
  logic             rx_en_r;
  logic             det_n_r;
  logic             res_n_r;
  logic             det_flag_r;
  logic             res_flag_r;
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [1:0]       hit_vec;
  logic [1:0]       act_vec;
  logic [1:0]       flag_vec;
  logic [CNT_W-1:0] cnt_vec [2];

  // Front-end inputs cross into the clock domain
  assign pins_async = '{detect_hit: detect_hit, reserve_hit: reserve_hit, trigger: trigger_in};

  lbf_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_async),
    .level    (pins_sync)
  );

  // Mode and timing decode
  wire        is_stand   = (cfg_r.mode == MODE_STANDALONE);
  wire        is_ctrl    = (cfg_r.mode == MODE_CONTROLLED);
  wire        us_tick    = (pre_r == PRE_LAST);
  wire [16:0] period_m1  = (cfg_r.scan_period == 17'h0) ? 17'h0 : cfg_r.scan_period - 17'h1;
  wire        period_end = us_tick && (us_r >= period_m1);
  wire        trig_rise  = pins_sync.trigger && !trig_prev_r;
  wire        start      = (is_stand && period_end) || (is_ctrl && trig_rise);
  wire [PLEN_W-1:0] plen_last = PLEN_W'((32'(cfg_r.pulse_length) + 32'h1) * CYC_PER_US - 1);
  // Compare with >= so that a shorter code written mid-pulse cannot let the count wrap
  wire        pulse_done = (plen_r >= plen_last);
  wire        slot       = (state_r == ST_EVAL);
  // A controlled slot sees hits only while the trigger still holds the window open; otherwise it counts as missing
  wire        rx_open    = is_stand || pins_sync.trigger;
  assign hit_vec = {pins_sync.reserve_hit & rx_open, pins_sync.detect_hit & rx_open};

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (start) state_nxt = ST_PULSE;
      ST_PULSE: if (pulse_done) state_nxt = ST_EVAL;
      ST_EVAL:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // Scan timer and pulse sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r     <= ST_IDLE;
      pre_r       <= '0;
      us_r        <= '0;
      plen_r      <= '0;
      trig_prev_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      trig_prev_r <= pins_sync.trigger;
      pre_r       <= us_tick ? '0 : pre_r + PRE_W'(1);
      if (period_end || !is_stand)
        us_r <= '0;
      else if (us_tick)
        us_r <= us_r + 17'h1;
      plen_r <= (state_r == ST_PULSE) ? plen_r + PLEN_W'(1) : '0;
    end
  end

  // Two filter paths: index 0 detect, index 1 reserve
  for (genvar g = 0; g < 2; g++)
  begin : g_path
    lbf_filter u_filter (
      .pclk           (pclk),
      .presetn        (presetn),
      .slot           (slot),
      .hit            (hit_vec[g]),
      .valid_weight   (cfg_r.valid_weight),
      .missing_weight (cfg_r.missing_weight),
      .count          (cnt_vec[g]),
      .active         (act_vec[g]),
      .pulse_flag     (flag_vec[g])
    );
  end

  // Pin outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_out_r  <= 1'b0;
      rx_en_r    <= 1'b0;
      det_n_r    <= 1'b1;
      res_n_r    <= 1'b1;
      det_flag_r <= 1'b0;
      res_flag_r <= 1'b0;
    end
    else
    begin
      led_out_r  <= (state_nxt == ST_PULSE) ^ cfg_r.led_drive_sense;
      rx_en_r    <= is_ctrl ? pins_sync.trigger : (state_nxt == ST_PULSE);
      det_n_r    <= !act_vec[0];
      res_n_r    <= !(act_vec[1] && act_vec[0]);
      det_flag_r <= flag_vec[0];
      res_flag_r <= flag_vec[1];
    end
  end

  // APB slave: zero wait states, answer registered in the setup cycle
  wire setup_ph = psel && !penable;
  wire wr_acc   = psel && penable && pready_r && pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_per  = (paddr == OFS_PERIOD);
  wire hit_flt  = (paddr == OFS_FILTER);
  wire hit_stat = (paddr == OFS_STATUS);
  wire hit_cnt  = (paddr == OFS_COUNT);
  wire mapped   = hit_ctrl || hit_per || hit_flt || hit_stat || hit_cnt;
  wire ro_write = pwrite && (hit_stat || hit_cnt);

  wire [31:0] rd_ctrl = (32'(cfg_r.mode) << CTRL_MODE_LSB)
                      | (32'(cfg_r.pulse_length) << CTRL_PLEN_LSB)
                      | (32'(cfg_r.led_drive_sense) << CTRL_SENSE_BIT);
  wire [31:0] rd_flt  = (32'(cfg_r.valid_weight) << FLT_INC_LSB)
                      | (32'(cfg_r.missing_weight) << FLT_DEC_LSB)
                      | (32'(cfg_r.detect_threshold) << FLT_TDET_LSB)
                      | (32'(cfg_r.reserve_threshold) << FLT_TRES_LSB);
  wire [31:0] rd_stat = {28'h0, pins_sync.trigger, act_vec[1], !res_n_r, !det_n_r};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl
                      : hit_per  ? 32'(cfg_r.scan_period)
                      : hit_flt  ? rd_flt
                      : hit_stat ? rd_stat
                      : hit_cnt  ? {cnt_vec[1], cnt_vec[0]}
                      : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      cfg_r     <= '{mode: RST_MODE, led_drive_sense: 1'b0, pulse_length: RST_PLEN,
                     scan_period: RST_PERIOD, valid_weight: RST_INC,
                     missing_weight: RST_DEC, detect_threshold: RST_THR,
                     reserve_threshold: RST_THR};
    end
    else
    begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && (!mapped || ro_write);
      prdata_r  <= (setup_ph && !pwrite) ? rd_mux : '0;
      if (wr_acc && hit_ctrl)
      begin
        cfg_r.mode            <= pwdata[CTRL_MODE_LSB +: 3];
        cfg_r.pulse_length    <= pwdata[CTRL_PLEN_LSB +: 3];
        cfg_r.led_drive_sense <= pwdata[CTRL_SENSE_BIT];
      end
      if (wr_acc && hit_per)
        cfg_r.scan_period <= pwdata[16:0];
      if (wr_acc && hit_flt)
      begin
        cfg_r.valid_weight      <= pwdata[FLT_INC_LSB +: 5];
        cfg_r.missing_weight    <= pwdata[FLT_DEC_LSB +: 4];
        cfg_r.detect_threshold  <= pwdata[FLT_TDET_LSB +: 4];
        cfg_r.reserve_threshold <= pwdata[FLT_TRES_LSB +: 4];
      end
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign led_out            = led_out_r;
  assign rx_enable          = rx_en_r;
  assign detect_threshold   = cfg_r.detect_threshold;
  assign reserve_threshold  = cfg_r.reserve_threshold;
  assign detect_out_n       = det_n_r;
  assign detect_out_alt     = det_n_r;
  assign reserve_out_n      = res_n_r;
  assign detect_pulse_flag  = det_flag_r;
  assign reserve_pulse_flag = res_flag_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ctrl_one_pulse: assert property (is_ctrl && $stable(cfg_r.mode)
    && $rose(state_r == ST_PULSE) |-> $past(trig_rise))
    else $error("controlled pulse without trigger edge");
  a_pulse_len: assert property (state_r == ST_PULSE && state_nxt != ST_PULSE
    |-> plen_r >= PLEN_W'(CYC_PER_US - 1))
    else $error("LED pulse shorter than one microsecond");
  a_led_polar: assert property (state_r == ST_IDLE && $stable(state_r)
    && $stable(cfg_r.led_drive_sense) |-> led_out == cfg_r.led_drive_sense)
    else $error("LED not idle per drive sense");
  a_cnt_max: assert property (cnt_vec[0] <= CNT_W'(CNT_MAX) && cnt_vec[1] <= CNT_W'(CNT_MAX))
    else $error("filter counter above limit");
  a_det_low_max: assert property (cnt_vec[0] == CNT_W'(CNT_MAX) && !slot
    |-> ##1 !detect_out_n)
    else $error("detect not low at upper limit");
  a_det_high_zero: assert property (slot && !hit_vec[0] && cnt_vec[0] <= 16'h0001
    |-> ##2 detect_out_n)
    else $error("detect not released at zero");
  a_hold_noslot: assert property (!slot |=> $stable(cnt_vec[0]) && $stable(cnt_vec[1]))
    else $error("filter moved outside a slot");
  a_res_with_det: assert property (detect_out_n |-> reserve_out_n)
    else $error("reserve active without detect");
  a_stand_period: assert property (is_stand && $rose(state_r == ST_PULSE) ##1
    $stable(cfg_r)[*8] |-> us_r <= period_m1 + 17'h1)
    else $error("scan timer past period");
  a_trig_rx: assert property (is_ctrl && $stable(cfg_r.mode) |=> rx_enable ==
    $past(pins_sync.trigger))
    else $error("receive window not following trigger");

  c_stand_slot: cover property (is_stand && slot);
  c_ctrl_slot:  cover property (is_ctrl && slot && hit_vec[0]);
  c_det_on:     cover property ($fell(detect_out_n));
  c_res_on:     cover property ($fell(reserve_out_n));
endmodule : lbf_core

// >>> common/lbf_pkg.sv
// Shared constants, register map and carrier types of the light barrier pulse filter
package lbf_pkg;
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRE_W         = 5;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
  localparam int unsigned PLEN_W        = 8;

  // Mode field encodings
  localparam logic [2:0] MODE_STANDALONE = 3'h5;
  localparam logic [2:0] MODE_CONTROLLED = 3'h3;

  // Filter counter and synchroniser depth
  localparam int unsigned CNT_W        = 16;
  localparam logic [16:0] CNT_MAX      = 17'h08000;
  localparam logic [16:0] INC_UNIT_SH  = 17'h0000a;
  localparam logic [16:0] INC_ZERO_VAL = 17'h08000;
  localparam int unsigned SYNC_N       = 3;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_FILTER = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;

  // Field positions
  localparam int unsigned CTRL_SENSE_BIT = 1;
  localparam int unsigned CTRL_PLEN_LSB  = 2;
  localparam int unsigned CTRL_MODE_LSB  = 12;
  localparam int unsigned FLT_INC_LSB    = 0;
  localparam int unsigned FLT_DEC_LSB    = 8;
  localparam int unsigned FLT_TDET_LSB   = 16;
  localparam int unsigned FLT_TRES_LSB   = 20;

  // Reset values
  localparam logic [2:0]  RST_MODE   = MODE_STANDALONE;
  localparam logic [2:0]  RST_PLEN   = 3'h1;
  localparam logic [16:0] RST_PERIOD = 17'h00064;
  localparam logic [4:0]  RST_INC    = 5'h00;
  localparam logic [3:0]  RST_DEC    = 4'h0;
  localparam logic [3:0]  RST_THR    = 4'h0;

  typedef struct packed {
    logic [2:0]  mode;
    logic        led_drive_sense;
    logic [2:0]  pulse_length;
    logic [16:0] scan_period;
    logic [4:0]  valid_weight;
    logic [3:0]  missing_weight;
    logic [3:0]  detect_threshold;
    logic [3:0]  reserve_threshold;
  } lbf_cfg_t;

  typedef struct packed {
    logic detect_hit;
    logic reserve_hit;
    logic trigger;
  } lbf_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PULSE = 3'b010,
    ST_EVAL  = 3'b100
  } lbf_state_t;
endpackage : lbf_pkg

// >>> rtl/lbf_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ns
module lbf_sync (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire lbf_pkg::lbf_pins_t   async_in,
  output      lbf_pkg::lbf_pins_t   level
);
  import lbf_pkg::*;

  lbf_pins_t s1_r;
  lbf_pins_t s2_r;
  lbf_pins_t s3_r;
  lbf_pins_t level_r;

  // Level changes only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      level_r <= '0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < $bits(lbf_pins_t); i++)
        if (s2_r[i] == s3_r[i])
          level_r[i] <= s3_r[i];
    end
  end

  assign level = level_r;
endmodule : lbf_sync

// >>> rtl/lbf_filter.sv
// Saturating weighted up/down counter with hysteresis output for one threshold path
`timescale 1ns/1ns
module lbf_filter (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        slot,
  input  wire logic                        hit,
  input  wire logic [4:0]                  valid_weight,
  input  wire logic [3:0]                  missing_weight,
  output      logic [lbf_pkg::CNT_W-1:0]   count,
  output      logic                        active,
  output      logic                        pulse_flag
);
  import lbf_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             active_r;
  logic             flag_r;
  logic [16:0]      inc_amt;
  logic [16:0]      up_sum;
  logic [CNT_W-1:0] dec_amt;
  logic             at_max;
  logic             at_zero;

  // Weight zero counts as thirty-two
  assign inc_amt = (valid_weight == 5'h00) ? INC_ZERO_VAL
                 : (17'(valid_weight) << INC_UNIT_SH);
  assign up_sum  = 17'(cnt_r) + inc_amt;
  assign dec_amt = CNT_W'(16'h0001 << missing_weight);
  assign at_max  = (up_sum >= CNT_MAX);
  assign at_zero = (cnt_r <= dec_amt);

  assign cnt_nxt = !slot ? cnt_r
                 : hit ? (at_max ? CNT_W'(CNT_MAX) : up_sum[CNT_W-1:0])
                 : (at_zero ? '0 : cnt_r - dec_amt);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r    <= '0;
      active_r <= 1'b0;
      flag_r   <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      flag_r <= slot & hit;
      // Between the limits the state holds
      if (slot && hit && at_max)
        active_r <= 1'b1;
      else if (slot && !hit && at_zero)
        active_r <= 1'b0;
    end
  end

  assign count      = cnt_r;
  assign active     = active_r;
  assign pulse_flag = flag_r;
endmodule : lbf_filter

// >>> testbench/lbf_frontend.sv
// Behavioural LED driver and photodiode comparator front end
`timescale 1ns/1ns
module lbf_frontend (
  input  wire logic pclk,
  input  wire logic led_out,
  input  wire logic led_drive_sense,
  input  wire logic beam_det,
  input  wire logic beam_res,
  output      logic detect_hit,
  output      logic reserve_hit
);
  logic [3:0] hold_r = 4'h0;
  wire        lit;
  // Light only while the LED sits at its active level
  assign lit = (led_out === ~led_drive_sense);
  always @(posedge pclk)
  begin
    if (lit)
      hold_r <= 4'ha;
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
  end
  // Result held briefly past the flash, then back to dark
  assign detect_hit  = beam_det & (lit | (hold_r != 4'h0));
  assign reserve_hit = beam_res & (lit | (hold_r != 4'h0));
endmodule : lbf_frontend

// >>> testbench/tb_light_barrier_pulse_filter.sv
// Self-checking testbench of the light barrier pulse filter core
`timescale 1ns/1ns
module tb_light_barrier_pulse_filter;
  import lbf_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        trigger_in = 1'b0;
  logic        beam_det = 1'b0;
  logic        beam_res = 1'b0;
  logic        sense = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, detect_hit, reserve_hit, led_out, rx_enable;
  logic        detect_out_n, detect_out_alt, reserve_out_n;
  logic        detect_pulse_flag, reserve_pulse_flag;
  logic [3:0]  detect_threshold, reserve_threshold;
  int          errors = 0;
  int          num_checks = 0;
  int          seed = 98;
  int          starts = 0;
  int          n, n0, ln, tn;
  logic        led_q = 1'b0;
  logic [31:0] rd;
  logic        err;
  logic [16:0] cd, cr;
  logic        ad, ar;
  logic [4:0]  w;
  logic [3:0]  d;

  always #25 pclk = ~pclk;

  lbf_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_in(trigger_in), .detect_hit(detect_hit),
    .reserve_hit(reserve_hit), .led_out(led_out), .rx_enable(rx_enable),
    .detect_threshold(detect_threshold), .reserve_threshold(reserve_threshold),
    .detect_out_n(detect_out_n), .detect_out_alt(detect_out_alt),
    .reserve_out_n(reserve_out_n), .detect_pulse_flag(detect_pulse_flag),
    .reserve_pulse_flag(reserve_pulse_flag));

  lbf_frontend front (.pclk(pclk), .led_out(led_out), .led_drive_sense(sense),
    .beam_det(beam_det), .beam_res(beam_res), .detect_hit(detect_hit),
    .reserve_hit(reserve_hit));

  always @(posedge pclk)
  begin
    led_q <= (led_out === ~sense);
    if ((led_out === ~sense) && !led_q)
      starts <= starts + 1;
  end

  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    check("pready", 32'(k < 20), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wait_led(input logic on);
    int k;
    k = 0;
    while (led_out !== (on ? ~sense : sense) && k < 5000)
    begin
      @(posedge pclk);
      k++;
    end
    check("led wait", 32'(k < 5000), 32'h1);
  endtask : wait_led

  task do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("reset outs", 32'({detect_out_n, reserve_out_n, led_out, pready}), 32'hc);
    presetn <= 1'b1;
    @(posedge pclk);
    cd = 17'h0;
    cr = 17'h0;
    ad = 1'b0;
    ar = 1'b0;
  endtask : do_reset

  function automatic logic [16:0] fnext(logic [16:0] c, logic hit, logic [4:0] wt,
                                        logic [3:0] dw);
    logic [17:0] s;
    s = {1'b0, c} + ((wt == 5'h0) ? 18'h08000 : {3'h0, wt, 10'h0});
    if (hit)
      return (s > 18'h08000) ? 17'h08000 : s[16:0];
    return (c >= (17'h1 << dw)) ? c - (17'h1 << dw) : 17'h0;
  endfunction : fnext

  task slot(input logic hd, input logic hr);
    logic fd, fr;
    beam_det <= hd;
    beam_res <= hr;
    wait_led(1'b1);
    wait_led(1'b0);
    fd = 1'b0;
    fr = 1'b0;
    repeat (6)
    begin
      @(posedge pclk);
      fd |= detect_pulse_flag;
      fr |= reserve_pulse_flag;
    end
    cd = fnext(cd, hd, w, d);
    cr = fnext(cr, hr, w, d);
    ad = (cd == CNT_MAX) ? 1'b1 : ((cd == 17'h0) ? 1'b0 : ad);
    ar = (cr == CNT_MAX) ? 1'b1 : ((cr == 17'h0) ? 1'b0 : ar);
    apb(1'b0, OFS_COUNT, 32'h0);
    check("count", rd, {cr[15:0], cd[15:0]});
    check("flags", 32'({fd, fr}), 32'({hd, hr}));
    check("outputs", 32'({detect_out_n, detect_out_alt, reserve_out_n}),
          32'({~ad, ~ad, ~(ar & ad)}));
  endtask : slot

  initial
  begin
    #5000000;
    errors++;
    $display("FAIL watchdog expected done seen hang");
    summarize();
  end

  initial
  begin
    do_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h00005004);
    apb(1'b0, OFS_PERIOD, 32'h0);
    check("period reset", rd, 32'h00000064);
    apb(1'b0, OFS_FILTER, 32'h0);
    check("filter reset", rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    check("ro write", 32'(err), 32'h1);
    apb(1'b1, OFS_PERIOD, 32'h0000000a);
    for (int code = 0; code < 6; code++)
    begin
      sense = 1'($random(seed));
      apb(1'b1, OFS_CTRL, 32'h00005000 | 32'(code << 2) | 32'({sense, 1'b0}));
      wait_led(1'b1);
      wait_led(1'b0);
      wait_led(1'b1);
      ln = 0;
      while (led_out === ~sense && ln < 400)
      begin
        @(posedge pclk);
        ln++;
      end
      tn = ln;
      while (led_out === sense && tn < 400)
      begin
        @(posedge pclk);
        tn++;
      end
      check("pulse len", 32'(ln), 32'((code + 1) * 20));
      check("scan period", 32'(tn), 32'h000000c8);
    end
    sense = 1'b0;
    do_reset();
    apb(1'b1, OFS_PERIOD, 32'h0000000a);
    for (int s = 0; s < 3; s++)
    begin
      w = (s == 0) ? 5'h0 : 5'($random(seed));
      d = (s == 0) ? 4'hf : 4'($random(seed));
      apb(1'b1, OFS_FILTER, {8'h00, 4'h9, 4'h6, 4'h0, d, 3'h0, w});
      check("thresholds", 32'({reserve_threshold, detect_threshold}), 32'h96);
      apb(1'b1, OFS_CTRL, 32'h00005000);
      if (s == 0)
      begin
        wait_led(1'b1);
        wait_led(1'b0);
        repeat (8) @(posedge pclk);
      end
      for (int i = 0; i < 24; i++)
        slot(((i < 12) == ((3'($random(seed))) != 3'h0)),
             ((i < 12) == ((3'($random(seed))) != 3'h0)));
    end
    // Scan period left at its standalone value; controlled mode does not use it
    w = 5'h0;
    d = 4'hf;
    apb(1'b1, OFS_FILTER, {8'h00, 4'h9, 4'h6, 4'h0, d, 3'h0, w});
    apb(1'b1, OFS_CTRL, 32'h00003000);
    repeat (60) @(posedge pclk);
    beam_det <= 1'b1;
    beam_res <= 1'b1;
    n0 = starts;
    trigger_in <= 1'b1;
    n = 0;
    while (led_out !== ~sense && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    check("trigger delay", 32'(n >= 2 && n <= 8), 32'h1);
    repeat (60) @(posedge pclk);
    check("rx on", 32'(rx_enable), 32'h1);
    trigger_in <= 1'b0;
    repeat (100) @(posedge pclk);
    check("rx off", 32'(rx_enable), 32'h0);
    check("one pulse", 32'(starts - n0), 32'h1);
    apb(1'b0, OFS_COUNT, 32'h0);
    check("ctl count", rd, 32'h80008000);
    check("ctl detect", 32'({detect_out_n, reserve_out_n}), 32'h0);
    n0 = starts;
    trigger_in <= 1'b1;
    repeat (6) @(posedge pclk);
    trigger_in <= 1'b0;
    repeat (100) @(posedge pclk);
    check("short pulse", 32'(starts - n0), 32'h1);
    apb(1'b0, OFS_COUNT, 32'h0);
    check("ctl missing", rd, 32'h0);
    check("ctl release", 32'({detect_out_n, reserve_out_n}), 32'h3);
    apb(1'b1, OFS_CTRL, 32'h0);
    n0 = starts;
    repeat (400) @(posedge pclk);
    check("no mode", 32'(starts - n0), 32'h0);
    summarize();
  end
endmodule : tb_light_barrier_pulse_filter
